// [aqs_bus_master.sv]
`timescale 1ns/10ps
module aqs_bus_master (
  input  wire logic clock,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_rel,
  output logic      sda_rel
);
  int stretch_n;

  initial begin
    scl_rel   = 1'b1;
    sda_rel   = 1'b1;
    stretch_n = 0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic start_cond();
    sda_rel <= 1'b0;
    wait_n(5);
    scl_rel <= 1'b0;
    wait_n(5);
  endtask

  task automatic stop_cond();
    sda_rel <= 1'b0;
    wait_n(5);
    scl_rel <= 1'b1;
    wait_n(5);
    sda_rel <= 1'b1;
    wait_n(5);
  endtask

  task automatic xbit(input logic b, output logic r);
    int n;
    n = 0;
    sda_rel <= b;
    wait_n(3);
    scl_rel <= 1'b1;
    @(negedge clock);
    while (!scl && n < 4000) begin
      @(negedge clock);
      n++;
    end
    stretch_n += n;
    repeat (4) @(negedge clock);
    r = sda;
    @(posedge clock);
    scl_rel <= 1'b0;
    wait_n(2);
  endtask

  task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(ack_in, ack);
  endtask
endmodule // aqs_bus_master

// [aqs_pkg.sv]
package aqs_pkg;
  localparam int          RESULT_BITS      = 10;
  localparam int          ADDR_BITS        = 7;
  localparam int          BYTE_BITS        = 8;
  localparam int          TX_BITS          = 16;
  localparam int          CHAN_SMALL       = 4;
  localparam int          CHAN_LARGE       = 12;
  localparam int          CLOCK_KHZ        = 125000;
  localparam int          MAX_SCL_KHZ      = 1700;
  localparam int          CONV_STEP_NS     = 64;
  localparam int          CONV_STEP_CYCLES = (CONV_STEP_NS * CLOCK_KHZ + 999999) / 1000000;
  localparam int          ACQ_HALF_INT     = 3;
  localparam int          ACQ_HALF_EXT     = 4;
  localparam logic [3:0]  ADDR_LAST_BIT    = 4'h7;
  localparam logic [3:0]  BYTE_DONE        = 4'h8;
  localparam logic [3:0]  EXT_HOLD_PULSE   = 4'h2;
  localparam int          BYTE_TYPE_BIT    = 7;
  localparam logic [6:0]  DEFAULT_ADDR     = 7'h2A;
  localparam logic [5:0]  RESULT_PAD       = 6'h3F;
  localparam logic [9:0]  SAR_FIRST        = 10'h200;
  localparam logic [3:0]  ACQ_HALF_INT_L   = 4'h3;
  localparam logic [3:0]  ACQ_HALF_EXT_L   = 4'h4;

  typedef enum {
    AQS_IDLE, AQS_ADDR, AQS_ADDR_ACK, AQS_WR_BYTE, AQS_WR_ACK,
    AQS_CONVERT, AQS_RD_BYTE, AQS_RD_ACK, AQS_IGNORE
  } aqs_state_t;

  typedef struct packed {
    logic [3:0] pos;
    logic [3:0] neg;
    logic       neg_ground;
  } aqs_mux_t;
endpackage

// [aqs_sar.sv]
`timescale 1ns/10ps
module aqs_sar #(
  parameter int W = aqs_pkg::RESULT_BITS
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic         start,
  input  wire logic         step,
  input  wire logic         comparator_above,
  output logic [W-1:0]      trial,
  output logic [W-1:0]      result,
  output logic              done,
  output logic              busy
);
  logic [W-1:0] mask;

  // one bit resolved per step, msb first
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      trial  <= '0;
      mask   <= '0;
      busy   <= 1'b0;
      done   <= 1'b0;
      result <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        trial <= aqs_pkg::SAR_FIRST;
        mask  <= aqs_pkg::SAR_FIRST;
        busy  <= 1'b1;
      end else if (busy && step) begin
        if (mask[0]) begin
          result <= comparator_above ? trial : (trial & ~mask);
          busy   <= 1'b0;
          done   <= 1'b1;
        end else begin
          trial <= (comparator_above ? trial : (trial & ~mask)) | (mask >> 1);
        end
        mask <= mask >> 1;
      end
    end
  end
endmodule // aqs_sar

// [aqs_sequencer.sv]
// Functional notes
// - internal clock mode: track starts on the eighth rising scl edge of a matching address byte.
// - internal clock mode: hold starts on the falling scl edge of the address acknowledge pulse.
// - internal clock mode: conversion runs from the local clock while scl is held low by the device.
// - external clock mode: track starts on the rising scl edge of the read/write bit when it is 1.
// - external clock mode: hold starts on the second rising scl edge of the first result byte.
// - external clock mode: conversion steps on the 10 scl rising edges after hold.
// - each conversion resolves one bit per conversion clock, 10 steps to a 10-bit result.
// - acquisition lasts 1.5 scl periods internally clocked and 2 scl periods externally clocked.
// - pairing select 1 converts the chosen single input against ground.
// - pairing select 0 converts the difference of the chosen input pair.
// - the mux offers 4 channels on the small variant and 12 on the large one.
// - the top analog input doubles as reference pin according to the setup selection.
// - scl and sda are both two-way lines (scl held low by the device during internally clocked conversion), for bus rates up to 1.7 MHz.
// - a written byte with msb 1 is the setup byte, with msb 0 the configuration byte.
// - the address lsb picks direction: 0 master writes, 1 master reads.
`timescale 1ns/10ps
module aqs_sequencer #(
  parameter bit         LARGE_VARIANT = 1'b1,
  parameter logic [6:0] SLAVE_ADDR    = aqs_pkg::DEFAULT_ADDR,
  parameter int         STEP_CYCLES   = aqs_pkg::CONV_STEP_CYCLES
) (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  input  wire logic                 scl_in,
  output logic                      scl_out,
  output logic                      scl_oe_n,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe_n,
  input  wire logic                 ext_clock_mode,
  input  wire logic                 input_pairing_select,
  input  wire logic [3:0]           channel_select,
  input  wire logic                 reference_select,
  input  wire logic                 comparator_above,
  output logic                      track,
  output logic                      acquisition_time,
  output aqs_pkg::aqs_mux_t         mux_sel,
  output logic                      shared_input_reference_pin,
  output logic [9:0]                dac_trial,
  output logic [9:0]                result,
  output logic                      result_valid,
  output logic [7:0]                setup_byte,
  output logic                      setup_write,
  output logic [7:0]                config_byte,
  output logic                      config_write
);
  localparam logic [3:0] NUM_CH = LARGE_VARIANT ? 4'(aqs_pkg::CHAN_LARGE) : 4'(aqs_pkg::CHAN_SMALL);

  aqs_pkg::aqs_state_t state;
  logic [1:0]  scl_sync;
  logic [1:0]  sda_sync;
  logic [1:0]  cmp_sync;
  logic        scl_prev;
  logic        sda_prev;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift_in;
  logic        rw;
  logic        addr_hit;
  logic        sda_low;
  logic        byte_idx;
  logic [15:0] tx_shift;
  logic [15:0] tx_word;
  logic        rise8_hit;
  logic        sar_start;
  logic        sar_step;
  logic        sar_done;
  logic        sar_busy;
  logic        conv_ext;
  logic [7:0]  div_cnt;
  logic [3:0]  acq_cnt;
  logic [9:0]  sar_result;
  logic        next_track;

  // two-stage synchronisers on the pins and comparator
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      cmp_sync <= 2'h0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      cmp_sync <= {cmp_sync[0], comparator_above};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  assign scl_rise  = scl_sync[1] & ~scl_prev;
  assign scl_fall  = ~scl_sync[1] & scl_prev;
  assign bus_start = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
  assign bus_stop  = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];
  assign rise8_hit = (state == aqs_pkg::AQS_ADDR) && scl_rise && (bit_cnt == aqs_pkg::ADDR_LAST_BIT)
                     && (shift_in[6:0] == SLAVE_ADDR);
  assign tx_word   = {aqs_pkg::RESULT_PAD, result};

  // open-drain drivers, enable low while pulling low
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~sda_low;
  assign scl_out  = 1'b0;
  assign scl_oe_n = ~(state == aqs_pkg::AQS_CONVERT);

  // serial protocol
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state        <= aqs_pkg::AQS_IDLE;
      bit_cnt      <= 4'h0;
      shift_in     <= 8'h00;
      rw           <= 1'b0;
      addr_hit     <= 1'b0;
      sda_low      <= 1'b0;
      byte_idx     <= 1'b0;
      tx_shift     <= 16'h0000;
      setup_byte   <= 8'h00;
      config_byte  <= 8'h00;
      setup_write  <= 1'b0;
      config_write <= 1'b0;
    end else begin
      setup_write  <= 1'b0;
      config_write <= 1'b0;
      if (bus_start) begin
        state   <= aqs_pkg::AQS_ADDR;
        bit_cnt <= 4'h0;
        sda_low <= 1'b0;
      end else if (bus_stop) begin
        state   <= aqs_pkg::AQS_IDLE;
        sda_low <= 1'b0;
      end else begin
        case (state)
          aqs_pkg::AQS_ADDR: begin
            if (scl_rise) begin
              shift_in <= {shift_in[6:0], sda_sync[1]};
              bit_cnt  <= bit_cnt + 4'h1;
              if (bit_cnt == aqs_pkg::ADDR_LAST_BIT) begin
                rw       <= sda_sync[1];
                addr_hit <= shift_in[6:0] == SLAVE_ADDR;
              end
            end else if (scl_fall && bit_cnt == aqs_pkg::BYTE_DONE) begin
              sda_low <= addr_hit;
              state   <= addr_hit ? aqs_pkg::AQS_ADDR_ACK : aqs_pkg::AQS_IGNORE;
            end
          end
          aqs_pkg::AQS_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt  <= 4'h0;
              byte_idx <= 1'b0;
              if (!rw) begin
                sda_low <= 1'b0;
                state   <= aqs_pkg::AQS_WR_BYTE;
              end else if (!ext_clock_mode) begin
                sda_low <= 1'b0;
                state   <= aqs_pkg::AQS_CONVERT;
              end else begin
                tx_shift <= tx_word;
                sda_low  <= ~tx_word[15];
                state    <= aqs_pkg::AQS_RD_BYTE;
              end
            end
          end
          aqs_pkg::AQS_WR_BYTE: begin
            if (scl_rise) begin
              shift_in <= {shift_in[6:0], sda_sync[1]};
              bit_cnt  <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == aqs_pkg::BYTE_DONE) begin
              sda_low <= 1'b1;
              state   <= aqs_pkg::AQS_WR_ACK;
              if (shift_in[aqs_pkg::BYTE_TYPE_BIT]) begin
                setup_byte  <= shift_in;
                setup_write <= 1'b1;
              end else begin
                config_byte  <= shift_in;
                config_write <= 1'b1;
              end
            end
          end
          aqs_pkg::AQS_WR_ACK: begin
            if (scl_fall) begin
              sda_low <= 1'b0;
              bit_cnt <= 4'h0;
              state   <= aqs_pkg::AQS_WR_BYTE;
            end
          end
          aqs_pkg::AQS_CONVERT: begin
            if (sar_done) begin
              tx_shift <= {aqs_pkg::RESULT_PAD, sar_result};
              sda_low  <= ~aqs_pkg::RESULT_PAD[5];
              state    <= aqs_pkg::AQS_RD_BYTE;
            end
          end
          aqs_pkg::AQS_RD_BYTE: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == aqs_pkg::BYTE_DONE) begin
                sda_low <= 1'b0;
                state   <= aqs_pkg::AQS_RD_ACK;
              end else begin
                tx_shift <= tx_shift << 1;
                sda_low  <= ~tx_shift[14];
              end
            end
          end
          aqs_pkg::AQS_RD_ACK: begin
            if (scl_rise && sda_sync[1]) begin
              state <= aqs_pkg::AQS_IGNORE;
            end else if (scl_fall) begin
              bit_cnt  <= 4'h0;
              byte_idx <= ~byte_idx;
              state    <= aqs_pkg::AQS_RD_BYTE;
              if (byte_idx) begin
                tx_shift <= tx_word;
                sda_low  <= ~tx_word[15];
              end else begin
                tx_shift <= tx_shift << 1;
                sda_low  <= ~tx_shift[14];
              end
            end
          end
          aqs_pkg::AQS_IGNORE: begin
            sda_low <= 1'b0;
          end
          default: begin
            state <= aqs_pkg::AQS_IDLE;
          end
        endcase
      end
    end
  end

  // track/hold switching and conversion start
  always_comb begin
    next_track = track;
    sar_start  = 1'b0;
    if (!ext_clock_mode) begin
      if (rise8_hit)
        next_track = 1'b1;
      if (track && state == aqs_pkg::AQS_ADDR_ACK && scl_fall) begin
        next_track = 1'b0;
        sar_start  = rw;
      end
    end else begin
      if (rise8_hit && sda_sync[1])
        next_track = 1'b1;
      if (track && state == aqs_pkg::AQS_RD_BYTE && !byte_idx && scl_rise
          && bit_cnt == aqs_pkg::EXT_HOLD_PULSE - 4'h1) begin
        next_track = 1'b0;
        sar_start  = 1'b1;
      end
    end
    if (bus_stop)
      next_track = 1'b0;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      track    <= 1'b0;
      conv_ext <= 1'b0;
    end else begin
      track <= next_track;
      if (sar_start)
        conv_ext <= ext_clock_mode;
    end
  end

  // acquisition window, counted in scl half periods
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      acq_cnt          <= 4'h0;
      acquisition_time <= 1'b0;
    end else if (!track) begin
      acq_cnt          <= 4'h0;
      acquisition_time <= 1'b0;
    end else if (scl_rise || scl_fall) begin
      acq_cnt <= acq_cnt + 4'h1;
      if (acq_cnt + 4'h1 >= (ext_clock_mode ? aqs_pkg::ACQ_HALF_EXT_L : aqs_pkg::ACQ_HALF_INT_L))
        acquisition_time <= 1'b1;
    end
  end

  // conversion clock: local divider or scl rising edges
  always_ff @(posedge clock) begin
    if (sys_rst || sar_start || !sar_busy)
      div_cnt <= 8'h00;
    else if (div_cnt == 8'(STEP_CYCLES - 1))
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'h01;
  end

  assign sar_step = conv_ext ? scl_rise : (div_cnt == 8'(STEP_CYCLES - 1));

  aqs_sar #(
    .W (aqs_pkg::RESULT_BITS)
  ) u_sar (
    .clock            (clock),
    .sys_rst          (sys_rst),
    .start            (sar_start),
    .step             (sar_step),
    .comparator_above (cmp_sync[1]),
    .trial            (dac_trial),
    .result           (sar_result),
    .done             (sar_done),
    .busy             (sar_busy)
  );

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      result       <= 10'h000;
      result_valid <= 1'b0;
    end else begin
      result_valid <= sar_done;
      if (sar_done)
        result <= sar_result;
    end
  end

  // input mux selection
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mux_sel                    <= '0;
      shared_input_reference_pin <= 1'b0;
    end else begin
      shared_input_reference_pin <= reference_select;
      if (channel_select >= NUM_CH || (reference_select && channel_select == NUM_CH - 4'h1)) begin
        mux_sel <= '0;
        mux_sel.neg_ground <= 1'b1;
      end else if (input_pairing_select) begin
        mux_sel.pos        <= channel_select;
        mux_sel.neg        <= 4'h0;
        mux_sel.neg_ground <= 1'b1;
      end else begin
        mux_sel.pos        <= channel_select;
        mux_sel.neg        <= channel_select ^ 4'h1;
        mux_sel.neg_ground <= 1'b0;
      end
    end
  end
endmodule // aqs_sequencer

// [aqs_sequencer_sva.sv]
`timescale 1ns/10ps
module aqs_sequencer_sva #(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter int STEP_CYCLES   = 8
) (
  input wire logic              clock,
  input wire logic              sys_rst,
  input wire logic              scl_oe_n,
  input wire logic              ext_clock_mode,
  input wire logic              input_pairing_select,
  input wire logic [3:0]        channel_select,
  input wire logic              reference_select,
  input wire logic              track,
  input wire logic              acquisition_time,
  input wire aqs_pkg::aqs_mux_t mux_sel,
  input wire logic [9:0]        result,
  input wire logic              result_valid,
  input wire logic [7:0]        setup_byte,
  input wire logic              setup_write,
  input wire logic [7:0]        config_byte,
  input wire logic              config_write
);
  localparam logic [3:0] TOP      = LARGE_VARIANT ? 4'(aqs_pkg::CHAN_LARGE - 1) : 4'(aqs_pkg::CHAN_SMALL - 1);
  localparam int         CONV_MIN = 10 * STEP_CYCLES;
  localparam int         CONV_MAX = CONV_MIN + 8;
  int stretch_cnt;

  // cycles of scl held low by the device
  always_ff @(posedge clock) begin
    if (sys_rst || scl_oe_n) begin
      stretch_cnt <= 0;
    end else begin
      stretch_cnt <= stretch_cnt + 1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  chk_stretch_hold: assert property ($fell(scl_oe_n) |-> ##[0:2] !track)
    else $error("stretch began while tracking");
  chk_conv_length: assert property ($rose(scl_oe_n) |-> stretch_cnt inside {[CONV_MIN:CONV_MAX]})
    else $error("stretch length differs from ten conversion steps");
  chk_valid_pulse: assert property (result_valid |=> !result_valid)
    else $error("result valid longer than one cycle");
  chk_result_cause: assert property ($changed(result) |-> result_valid)
    else $error("result changed without valid pulse");
  chk_mux_single: assert property (
    !$past(sys_rst) && $past(input_pairing_select) && $past(channel_select) < TOP
    |-> mux_sel == {$past(channel_select), 4'h0, 1'b1})
    else $error("single-ended mux selection wrong");
  chk_mux_diff: assert property (
    !$past(sys_rst) && !$past(input_pairing_select) && $past(channel_select) < TOP
    |-> mux_sel == {$past(channel_select), $past(channel_select) ^ 4'h1, 1'b0})
    else $error("differential mux selection wrong");
  chk_mux_range: assert property (
    !$past(sys_rst) && ($past(channel_select) > TOP || ($past(channel_select) == TOP && $past(reference_select)))
    |-> mux_sel == 9'h001)
    else $error("unavailable channel reached the mux");
  chk_setup_type: assert property (setup_write |-> setup_byte[7] && !config_write)
    else $error("setup byte without msb set");
  chk_config_type: assert property (config_write |-> !config_byte[7])
    else $error("configuration byte with msb set");
  chk_acq_early: assert property ($rose(track) |-> !acquisition_time [*8])
    else $error("acquisition flagged too early");
  chk_acq_done: assert property ($fell(track) |-> acquisition_time)
    else $error("hold entered before acquisition window ended");
  chk_ext_stretch: assert property (ext_clock_mode |-> scl_oe_n)
    else $error("scl stretched in external clock mode");
endmodule // aqs_sequencer_sva

bind aqs_sequencer aqs_sequencer_sva #(.LARGE_VARIANT(LARGE_VARIANT), .STEP_CYCLES(STEP_CYCLES)) u_sva (
  .clock(clock), .sys_rst(sys_rst), .scl_oe_n(scl_oe_n), .ext_clock_mode(ext_clock_mode),
  .input_pairing_select(input_pairing_select), .channel_select(channel_select),
  .reference_select(reference_select), .track(track), .acquisition_time(acquisition_time),
  .mux_sel(mux_sel), .result(result), .result_valid(result_valid), .setup_byte(setup_byte),
  .setup_write(setup_write), .config_byte(config_byte), .config_write(config_write)
);

// [aqs_sequencer_tb.sv]
`timescale 1ns/10ps
module aqs_sequencer_tb;
  logic              clock, sys_rst, ext_clock_mode, input_pairing_select, reference_select, comparator_above;
  logic [3:0]        channel_select;
  logic              scl_out, scl_oe_n, sda_out, sda_oe_n, track, acquisition_time, shared_input_reference_pin;
  aqs_pkg::aqs_mux_t mux_sel;
  logic [9:0]        dac_trial, result, vin, v, last;
  logic              result_valid, setup_write, config_write;
  logic [7:0]        setup_byte, config_byte;
  wire               m_scl, m_sda;
  wire               scl = m_scl & (scl_oe_n | scl_out);
  wire               sda = m_sda & (sda_oe_n | sda_out);
  int                fails, tests_run, cycles;
  logic [9:0]        rq[$];
  logic [7:0]        sq[$], cq[$];

  aqs_sequencer uut (
    .clock(clock), .sys_rst(sys_rst), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .ext_clock_mode(ext_clock_mode),
    .input_pairing_select(input_pairing_select), .channel_select(channel_select),
    .reference_select(reference_select), .comparator_above(comparator_above), .track(track),
    .acquisition_time(acquisition_time), .mux_sel(mux_sel),
    .shared_input_reference_pin(shared_input_reference_pin), .dac_trial(dac_trial), .result(result),
    .result_valid(result_valid), .setup_byte(setup_byte), .setup_write(setup_write),
    .config_byte(config_byte), .config_write(config_write)
  );
  aqs_bus_master bm (.clock(clock), .scl(scl), .sda(sda), .scl_rel(m_scl), .sda_rel(m_sda));

  always #4 clock = ~clock;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // analog input model and result watcher
  always @(posedge clock) begin
    comparator_above <= (vin >= dac_trial);
    if (result_valid === 1'b1) check("result", 16'(result), rq.size() ? 16'(rq.pop_front()) : 'x);
    if (setup_write === 1'b1) check("setup", 16'(setup_byte), sq.size() ? 16'(sq.pop_front()) : 'x);
    if (config_write === 1'b1) check("config", 16'(config_byte), cq.size() ? 16'(cq.pop_front()) : 'x);
    cycles++;
    if (cycles > 20000) begin
      fails++;
      end_sim();
    end
  end

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       ack;
    logic       hit;
    hit = (a == aqs_pkg::DEFAULT_ADDR);
    @(posedge clock);
    bm.start_cond();
    bm.xbyte({a, 1'b0}, 1'b1, q, ack);
    check("write addr ack", 16'(ack), 16'(!hit));
    if (hit && d[7]) sq.push_back(d);
    if (hit && !d[7]) cq.push_back(d);
    bm.xbyte(d, 1'b1, q, ack);
    check("data ack", 16'(ack), 16'(!hit));
    bm.stop_cond();
  endtask

  task automatic rd(input logic [9:0] exp, input logic [9:0] conv);
    logic [7:0] hi, lo;
    logic       ack;
    int         s0;
    s0 = bm.stretch_n;
    @(posedge clock);
    vin <= conv;
    rq.push_back(conv);
    bm.start_cond();
    bm.xbyte({aqs_pkg::DEFAULT_ADDR, 1'b1}, 1'b1, hi, ack);
    check("read addr ack", 16'(ack), 16'h0000);
    bm.xbyte(8'hFF, 1'b0, hi, ack);
    bm.xbyte(8'hFF, 1'b1, lo, ack);
    check("read data", {hi, lo}, {aqs_pkg::RESULT_PAD, exp});
    check("stretch", 16'(bm.stretch_n > s0), 16'(!ext_clock_mode));
    bm.stop_cond();
  endtask

  initial begin
    void'($urandom(32'h7A102B9C));
    clock = 1'b0;
    sys_rst = 1'b1;
    ext_clock_mode = 1'b0;
    input_pairing_select = 1'b1;
    channel_select = 4'h0;
    reference_select = 1'b0;
    vin = 10'h000;
    fails = 0;
    tests_run = 0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    check("idle pins", 16'({scl_oe_n, sda_oe_n, track}), 16'h0006);
    repeat (60) begin
      @(posedge clock);
      input_pairing_select <= 1'($urandom);
      channel_select <= 4'($urandom);
      reference_select <= 1'($urandom);
    end
    repeat (2) @(posedge clock);
    check("reference pin", 16'(shared_input_reference_pin), 16'(reference_select));
    wr(aqs_pkg::DEFAULT_ADDR, {1'b1, 7'($urandom)});
    wr(aqs_pkg::DEFAULT_ADDR, {1'b0, 7'($urandom)});
    wr(aqs_pkg::DEFAULT_ADDR ^ 7'h01, 8'h80);
    repeat (3) begin
      v = 10'($urandom);
      rd(v, v);
      last = v;
    end
    ext_clock_mode <= 1'b1;
    repeat (2) begin
      v = 10'($urandom);
      rd(last, v);
      last = v;
    end
    repeat (200) @(posedge clock);
    check("pending results", 16'(rq.size()), 16'h0000);
    end_sim();
  end
endmodule // aqs_sequencer_tb
